// file: hw/flash_block_code_protection.sv
/*
  Protection checker: judges each table read, table write and programmer
  request against the protection configuration bytes it holds, filters read
  data and answers grant or deny one cycle later.
  Assumes one request per enabled cycle, memory data offered with the request,
  and that the array behind it acts only on a grant.
*/
// Overview of operation
// - Boot block spans addresses zero through 0007FFh.
// - Block 0 ends at 003FFFh; later blocks are 16 Kbyte each.
// - Each block has external, table-write and cross-read protect bits.
// - External protect bit blocks programmer reads, writes and row erases only.
// - Table writes to a block with write-protect bit zero are suppressed.
// - Table reads from inside a cross-read protected block see true data.
// - Table reads from outside a cross-read protected block return zeros.
// - Ordinary writes only clear protection bits, never set them.
// - Only reset or programmer chip or block erase sets protection bits again.
// - EEPROM external protect blocks programmer EEPROM reads and writes.
// - EEPROM write protect blocks all EEPROM writes.
// - Core EEPROM reads ignore both EEPROM protect bits.
// - Config write protect guards config bytes; only programmer changes it.
// - Protect bytes sit at 300008h through 30000Dh.
// - Table reads fetch device ID; config bytes readable and writable.
// - Eight ID bytes end at 200007h, readable even when protected.
// - Protected memory needs block erase; row erase only unprotected.
`timescale 1ns/1ps
module flash_block_code_protection (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic small_variant,
  input wire logic req_valid,
  input wire flash_protect_pkg::source_t req_source,
  input wire flash_protect_pkg::op_t req_op,
  input wire flash_protect_pkg::space_t req_space,
  input wire logic [flash_protect_pkg::ADDR_W-1:0] req_addr,
  input wire logic [flash_protect_pkg::ADDR_W-1:0] instr_addr,
  input wire logic [7:0] req_wdata,
  input wire logic [7:0] mem_rdata,
  output logic resp_valid,
  output logic resp_grant,
  output logic [7:0] resp_rdata,
  output logic [7:0] block_external_protect,
  output logic [7:0] block_write_protect,
  output logic [7:0] block_crossread_protect,
  output logic [7:0] boot_eeprom_external_protect,
  output logic [7:0] boot_eeprom_config_write_protect,
  output logic [7:0] boot_crossread_protect
);
  import flash_protect_pkg::*;

  // ----------------------------------------------------------------
  // Protection configuration bytes
  // ----------------------------------------------------------------
  logic [7:0] block_ext_reg, block_wr_reg, block_xrd_reg;
  logic [7:0] boot_ee_ext_reg, boot_ee_cfg_wr_reg, boot_xrd_reg;
  logic [7:0] other_cfg_reg [CFG_FIRST_ADDR[3:0]:CFG_LAST_ADDR[3:0]];

  // ----------------------------------------------------------------
  // Address classification
  // ----------------------------------------------------------------
  function automatic logic [2:0] block_of(input logic [ADDR_W-1:0] a, input logic is_small);
    logic [ADDR_W-1:0] last;
    last = is_small ? MEM_END_SMALL : MEM_END_LARGE;
    if (a <= BOOT_END_ADDR) block_of = BOOT_INDEX;
    else if (a <= BLOCK0_END_ADDR) block_of = 3'h0;
    else if (a <= last) block_of = 3'(a >> BLOCK_SHIFT);
    else block_of = NO_BLOCK;
  endfunction

  logic [2:0] tgt_blk, src_blk;
  logic tgt_ext, tgt_wr, tgt_xrd, is_cfg, is_id, is_devid;
  logic grant_next;
  logic [7:0] rdata_next, cfg_rd;

  assign tgt_blk = block_of(req_addr, small_variant);
  assign src_blk = block_of(instr_addr, small_variant);
  assign is_cfg = req_addr >= CFG_FIRST_ADDR && req_addr <= CFG_LAST_ADDR;
  assign is_id = req_addr >= ID_FIRST_ADDR && req_addr <= ID_LAST_ADDR;
  assign is_devid = req_addr >= DEVID_FIRST_ADDR;

  // Per-block bits
  always_comb begin
    if (tgt_blk == BOOT_INDEX) begin
      tgt_ext = boot_ee_ext_reg[BOOT_EXT_BIT];
      tgt_wr = boot_ee_cfg_wr_reg[BOOT_WR_BIT];
      tgt_xrd = boot_xrd_reg[BOOT_XRD_BIT];
    end else if (tgt_blk < NO_BLOCK) begin
      tgt_ext = block_ext_reg[tgt_blk];
      tgt_wr = block_wr_reg[tgt_blk];
      tgt_xrd = block_xrd_reg[tgt_blk];
    end else begin
      tgt_ext = 1'b1;
      tgt_wr = 1'b1;
      tgt_xrd = 1'b1;
    end
  end

  always_comb begin
    unique case (req_addr)
      BLOCK_EXT_ADDR: cfg_rd = block_ext_reg;
      BOOT_EE_EXT_ADDR: cfg_rd = boot_ee_ext_reg;
      BLOCK_WR_ADDR: cfg_rd = block_wr_reg;
      BOOT_EE_CFG_WR_ADDR: cfg_rd = boot_ee_cfg_wr_reg;
      BLOCK_XRD_ADDR: cfg_rd = block_xrd_reg;
      BOOT_XRD_ADDR: cfg_rd = boot_xrd_reg;
      default: cfg_rd = is_cfg ? other_cfg_reg[req_addr[3:0]] : ZERO_BYTE;
    endcase
  end

  // ----------------------------------------------------------------
  // Access decision
  // ----------------------------------------------------------------
  always_comb begin
    grant_next = 1'b1;
    rdata_next = ZERO_BYTE;
    unique case (req_space)
      SPACE_PROG: begin
        if (tgt_blk == NO_BLOCK) begin
          grant_next = req_op == OP_READ;
        end else if (req_source == SRC_PROG) begin
          unique case (req_op)
            OP_READ, OP_WRITE: grant_next = tgt_ext;
            OP_ROW_ERASE: grant_next = tgt_ext && tgt_wr;
            default: grant_next = 1'b1;
          endcase
          if (req_op == OP_READ && tgt_ext) rdata_next = mem_rdata;
        end else begin
          unique case (req_op)
            OP_READ: begin
              // Blocked reads are granted but see zeros
              if (tgt_xrd || src_blk == tgt_blk) rdata_next = mem_rdata;
            end
            OP_WRITE, OP_ROW_ERASE: grant_next = tgt_wr;
            default: grant_next = 1'b0;
          endcase
        end
      end
      SPACE_EEPROM: begin
        if (req_op == OP_READ) begin
          grant_next = req_source == SRC_CORE || boot_ee_ext_reg[EE_EXT_BIT];
          if (grant_next) rdata_next = mem_rdata;
        end else if (req_op == OP_WRITE) begin
          grant_next = boot_ee_cfg_wr_reg[EE_WR_BIT] &&
                       (req_source == SRC_CORE || boot_ee_ext_reg[EE_EXT_BIT]);
        end else begin
          grant_next = req_source == SRC_PROG;
        end
      end
      SPACE_CONFIG: begin
        if (req_op == OP_READ) begin
          rdata_next = cfg_rd;
          grant_next = is_cfg;
        end else if (req_op == OP_WRITE) begin
          grant_next = is_cfg && boot_ee_cfg_wr_reg[CFG_WR_BIT];
        end else begin
          grant_next = req_source == SRC_PROG && req_op != OP_ROW_ERASE;
        end
      end
      default: begin
        // ID bytes and device ID ignore code protection
        if (req_op == OP_READ) begin
          grant_next = is_id || is_devid;
          rdata_next = grant_next ? mem_rdata : ZERO_BYTE;
        end else begin
          grant_next = is_id && req_op == OP_WRITE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Configuration byte updates
  // ----------------------------------------------------------------
  logic cfg_wr_go, erase_go;
  assign cfg_wr_go = clk_en && req_valid && req_space == SPACE_CONFIG &&
                     req_op == OP_WRITE && grant_next;
  // Chip erase, or block erase of program memory, restores the bits
  assign erase_go = clk_en && req_valid && req_source == SRC_PROG &&
                    (req_op == OP_CHIP_ERASE ||
                     (req_op == OP_BLOCK_ERASE && req_space == SPACE_PROG));

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      block_ext_reg <= ERASED_BYTE;
      block_wr_reg <= ERASED_BYTE;
      block_xrd_reg <= ERASED_BYTE;
      boot_ee_ext_reg <= ERASED_BYTE;
      boot_ee_cfg_wr_reg <= ERASED_BYTE;
      boot_xrd_reg <= ERASED_BYTE;
    end else if (erase_go) begin
      block_ext_reg <= ERASED_BYTE;
      block_wr_reg <= ERASED_BYTE;
      block_xrd_reg <= ERASED_BYTE;
      boot_ee_ext_reg <= ERASED_BYTE;
      boot_ee_cfg_wr_reg <= ERASED_BYTE;
      boot_xrd_reg <= ERASED_BYTE;
    end else if (cfg_wr_go) begin
      // AND keeps zeros: bits only move from one to zero
      unique case (req_addr)
        BLOCK_EXT_ADDR: block_ext_reg <= block_ext_reg & req_wdata;
        BOOT_EE_EXT_ADDR: boot_ee_ext_reg <= boot_ee_ext_reg & req_wdata;
        BLOCK_WR_ADDR: block_wr_reg <= block_wr_reg & req_wdata;
        BOOT_EE_CFG_WR_ADDR: begin
          // Core may not touch the config write-protect bit
          boot_ee_cfg_wr_reg <= boot_ee_cfg_wr_reg &
            (req_source == SRC_PROG ? req_wdata : (req_wdata | 8'(1 << CFG_WR_BIT)));
        end
        BLOCK_XRD_ADDR: block_xrd_reg <= block_xrd_reg & req_wdata;
        BOOT_XRD_ADDR: boot_xrd_reg <= boot_xrd_reg & req_wdata;
        default: begin
        end
      endcase
    end
  end

  // Other configuration bytes are plain storage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = CFG_FIRST_ADDR[3:0]; i <= CFG_LAST_ADDR[3:0]; i++) begin
        other_cfg_reg[i] <= ERASED_BYTE;
      end
    end else if (cfg_wr_go && req_addr < BLOCK_EXT_ADDR) begin
      other_cfg_reg[req_addr[3:0]] <= req_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Response
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
      resp_grant <= 1'b0;
      resp_rdata <= ZERO_BYTE;
    end else if (clk_en) begin
      resp_valid <= req_valid;
      resp_grant <= req_valid && grant_next;
      resp_rdata <= req_valid ? rdata_next : ZERO_BYTE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      block_external_protect <= ERASED_BYTE;
      block_write_protect <= ERASED_BYTE;
      block_crossread_protect <= ERASED_BYTE;
      boot_eeprom_external_protect <= ERASED_BYTE;
      boot_eeprom_config_write_protect <= ERASED_BYTE;
      boot_crossread_protect <= ERASED_BYTE;
    end else if (clk_en) begin
      block_external_protect <= block_ext_reg;
      block_write_protect <= block_wr_reg;
      block_crossread_protect <= block_xrd_reg;
      boot_eeprom_external_protect <= boot_ee_ext_reg;
      boot_eeprom_config_write_protect <= boot_ee_cfg_wr_reg;
      boot_crossread_protect <= boot_xrd_reg;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_core_wr_locked;
    clk_en && req_valid && req_source == SRC_CORE && req_space == SPACE_PROG &&
      req_op == OP_WRITE && tgt_blk != NO_BLOCK && !tgt_wr;
  endsequence

  a_wr_lock_deny: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_core_wr_locked |=> !resp_grant) else $error("locked write granted");
  a_xrd_zero_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && req_valid && req_source == SRC_CORE && req_space == SPACE_PROG &&
    req_op == OP_READ && tgt_blk != NO_BLOCK && !tgt_xrd && src_blk != tgt_blk
    |=> resp_rdata == ZERO_BYTE) else $error("cross read leaked");
  a_xrd_same_blk: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && req_valid && req_source == SRC_CORE && req_space == SPACE_PROG &&
    req_op == OP_READ && tgt_blk != NO_BLOCK && src_blk == tgt_blk
    |=> resp_rdata == $past(mem_rdata)) else $error("same block read lost");
  a_ext_deny: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && req_valid && req_source == SRC_PROG && req_space == SPACE_PROG &&
    req_op == OP_READ && tgt_blk != NO_BLOCK && !tgt_ext
    |=> !resp_grant && resp_rdata == ZERO_BYTE) else $error("ext read allowed");
  a_bits_one_way: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !erase_go |=> (block_wr_reg & ~$past(block_wr_reg)) == ZERO_BYTE)
    else $error("protect bit set");
  a_core_no_erase: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && req_valid && req_source == SRC_CORE && req_op == OP_CHIP_ERASE
    |=> !resp_grant) else $error("core erase granted");
  a_ee_wr_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && req_valid && req_space == SPACE_EEPROM && req_op == OP_WRITE &&
    !boot_ee_cfg_wr_reg[EE_WR_BIT] |=> !resp_grant) else $error("ee write granted");
  a_ee_core_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && req_valid && req_space == SPACE_EEPROM && req_op == OP_READ &&
    req_source == SRC_CORE |=> resp_grant) else $error("core ee read denied");
  a_cfg_wrc_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !boot_ee_cfg_wr_reg[CFG_WR_BIT] && !erase_go |=> !boot_ee_cfg_wr_reg[CFG_WR_BIT] ##0
    $stable(block_ext_reg)) else $error("config changed while locked");
endmodule

// file: hw/flash_protect_pkg.sv
/*
  Constants for the program-memory and data-EEPROM protection checker:
  address map, configuration byte addresses, bit positions and codes.
  Assumes 22-bit table addresses from the core and the programmer.
*/
package flash_protect_pkg;
  localparam int ADDR_W = 22;
  localparam int NUM_BLOCKS = 6;
  localparam logic [ADDR_W-1:0] BOOT_END_ADDR = 22'h0007ff;
  localparam logic [ADDR_W-1:0] BLOCK0_END_ADDR = 22'h003fff;
  localparam int BLOCK_SHIFT = 14;
  localparam logic [ADDR_W-1:0] MEM_END_LARGE = 22'h017fff;
  localparam logic [ADDR_W-1:0] MEM_END_SMALL = 22'h013fff;
  localparam logic [ADDR_W-1:0] ID_FIRST_ADDR = 22'h200000;
  localparam logic [ADDR_W-1:0] ID_LAST_ADDR = 22'h200007;
  localparam logic [ADDR_W-1:0] CFG_FIRST_ADDR = 22'h300000;
  localparam logic [ADDR_W-1:0] CFG_LAST_ADDR = 22'h30000d;
  localparam logic [ADDR_W-1:0] DEVID_FIRST_ADDR = 22'h3ffffe;
  localparam logic [ADDR_W-1:0] BLOCK_EXT_ADDR = 22'h300008;
  localparam logic [ADDR_W-1:0] BOOT_EE_EXT_ADDR = 22'h300009;
  localparam logic [ADDR_W-1:0] BLOCK_WR_ADDR = 22'h30000a;
  localparam logic [ADDR_W-1:0] BOOT_EE_CFG_WR_ADDR = 22'h30000b;
  localparam logic [ADDR_W-1:0] BLOCK_XRD_ADDR = 22'h30000c;
  localparam logic [ADDR_W-1:0] BOOT_XRD_ADDR = 22'h30000d;
  localparam int EE_EXT_BIT = 7;
  localparam int BOOT_EXT_BIT = 6;
  localparam int EE_WR_BIT = 7;
  localparam int BOOT_WR_BIT = 6;
  localparam int CFG_WR_BIT = 5;
  localparam int BOOT_XRD_BIT = 6;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [2:0] BOOT_INDEX = 3'h7;
  localparam logic [2:0] NO_BLOCK = 3'h6;

  typedef enum logic [1:0] {SRC_CORE, SRC_PROG} source_t;
  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_ROW_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE
  } op_t;
  typedef enum logic [1:0] {
    SPACE_PROG, SPACE_EEPROM, SPACE_CONFIG, SPACE_OTHER
  } space_t;
endpackage

// file: bench/flash_array_model.sv
/*
  Behavioural model of the program and EEPROM array behind the checker.
  Assumes the bench presents one request per cycle on the core clock.
*/
`timescale 1ns/1ps
module flash_array_model
  import flash_protect_pkg::*;
(
  input wire logic sys_clk,
  input wire logic req_valid,
  input wire logic [flash_protect_pkg::ADDR_W-1:0] req_addr,
  output logic [7:0] mem_rdata
);
  logic [7:0] idle_reg = 8'h00;

  // Idle data toggles so a stale byte never passes for a reply
  always_ff @(posedge sys_clk) begin
    idle_reg <= ~idle_reg;
  end

  // Array answers in the request cycle with an address pattern
  always_comb begin
    mem_rdata = req_valid ? (req_addr[7:0] ^ 8'ha5) : idle_reg;
  end
endmodule

// file: bench/tb.sv
/*
  Self-checking bench for the protection checker: core and programmer
  requests through one access task, each answer compared as it lands.
  Assumes the array model answers in the request cycle.
*/
`timescale 1ns/1ps
module tb;
  import flash_protect_pkg::*;
  localparam logic [1:0] G1 = 2'b11;
  localparam logic [1:0] G0 = 2'b10;
  localparam logic [1:0] GX = 2'b00;
  localparam logic [1:0] DT = 2'b11;
  localparam logic [1:0] DZ = 2'b10;
  localparam logic [1:0] NC = 2'b00;
  localparam logic [ADDR_W-1:0] IN0 = 22'h000900;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic small_variant = 1'b0;
  logic clk_en = 1'b1;
  logic req_valid = 1'b0;
  source_t req_source = SRC_CORE;
  op_t req_op = OP_READ;
  space_t req_space = SPACE_PROG;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [ADDR_W-1:0] instr_addr = '0;
  logic [7:0] req_wdata = 8'h00;
  logic [7:0] mem_rdata;
  logic resp_valid;
  logic resp_grant;
  logic [7:0] resp_rdata;
  logic [7:0] ext_b, ext_e, wr_b, wr_e, xrd_b, xrd_e;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;

  // ----------------------------------------
  // Design and array model
  // ----------------------------------------
  flash_block_code_protection dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .small_variant(small_variant), .req_valid(req_valid), .req_source(req_source),
    .req_op(req_op), .req_space(req_space), .req_addr(req_addr), .instr_addr(instr_addr),
    .req_wdata(req_wdata), .mem_rdata(mem_rdata), .resp_valid(resp_valid),
    .resp_grant(resp_grant), .resp_rdata(resp_rdata), .block_external_protect(ext_b),
    .block_write_protect(wr_b), .block_crossread_protect(xrd_b),
    .boot_eeprom_external_protect(ext_e), .boot_eeprom_config_write_protect(wr_e),
    .boot_crossread_protect(xrd_e));
  flash_array_model array_model (.sys_clk(sys_clk), .req_valid(req_valid),
    .req_addr(req_addr), .mem_rdata(mem_rdata));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Checking and access tasks
  // ----------------------------------------
  function automatic logic [7:0] pbyte(input logic [3:0] lo);
    case (lo)
      4'h8: pbyte = ext_b;
      4'h9: pbyte = ext_e;
      4'ha: pbyte = wr_b;
      4'hb: pbyte = wr_e;
      4'hc: pbyte = xrd_b;
      default: pbyte = xrd_e;
    endcase
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request across the taking edge, then reads the answer
  task automatic acc(input source_t s, input op_t o, input space_t sp,
      input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ia, input logic [7:0] wd,
      input logic [1:0] eg, input logic [1:0] ed);
    // One idle edge between transfers, so valid never drops and rises in one step
    @(posedge sys_clk);
    #1;
    req_valid = 1'b1;
    req_source = s;
    req_op = o;
    req_space = sp;
    req_addr = a;
    instr_addr = ia;
    req_wdata = wd;
    @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
    chk("resp_valid", 8'h01, {7'h00, resp_valid});
    if (eg[1]) begin
      chk("resp_grant", {7'h00, eg[0]}, {7'h00, resp_grant});
    end
    if (ed[1]) begin
      chk("resp_rdata", ed[0] ? (a[7:0] ^ 8'ha5) : 8'h00, resp_rdata);
    end
  endtask

  task automatic rd(input source_t s, input space_t sp, input logic [ADDR_W-1:0] a,
      input logic [ADDR_W-1:0] ia, input logic [1:0] eg, input logic [1:0] ed);
    acc(s, OP_READ, sp, a, ia, 8'h00, eg, ed);
  endtask

  task automatic wr(input source_t s, input space_t sp, input logic [ADDR_W-1:0] a,
      input logic [1:0] eg);
    acc(s, OP_WRITE, sp, a, IN0, 8'h5a, eg, NC);
  endtask

  // Protect outputs lag the write by one more edge
  task automatic cfg(input source_t s, input logic [ADDR_W-1:0] a, input logic [7:0] d,
      input logic [1:0] eg, input logic [7:0] ex);
    acc(s, OP_WRITE, SPACE_CONFIG, a, IN0, d, eg, NC);
    @(posedge sys_clk);
    #1;
    chk("protect byte", ex, pbyte(a[3:0]));
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    for (int i = 8; i < 14; i++) begin
      chk("reset byte", 8'hff, pbyte(i[3:0]));
    end
    $display("test reset done");
    rd(SRC_CORE, SPACE_PROG, 22'h004010, IN0, G1, DT);
    cfg(SRC_CORE, BLOCK_XRD_ADDR, 8'hfd, G1, 8'hfd);
    rd(SRC_CORE, SPACE_PROG, 22'h004010, 22'h000100, G1, DZ);
    rd(SRC_CORE, SPACE_PROG, 22'h004010, 22'h007fff, G1, DT);
    cfg(SRC_CORE, BLOCK_XRD_ADDR, 8'hff, G1, 8'hfd);
    $display("test cross read done");
    cfg(SRC_CORE, BLOCK_WR_ADDR, 8'hfb, G1, 8'hfb);
    wr(SRC_CORE, SPACE_PROG, 22'h008000, G0);
    wr(SRC_CORE, SPACE_PROG, 22'h00c000, G1);
    cfg(SRC_CORE, BOOT_EE_CFG_WR_ADDR, 8'hbf, G1, 8'hbf);
    wr(SRC_CORE, SPACE_PROG, 22'h0007ff, G0);
    wr(SRC_CORE, SPACE_PROG, 22'h000800, G1);
    $display("test write protect done");
    cfg(SRC_CORE, BLOCK_EXT_ADDR, 8'hef, G1, 8'hef);
    rd(SRC_PROG, SPACE_PROG, 22'h010000, IN0, G0, DZ);
    wr(SRC_PROG, SPACE_PROG, 22'h010000, G0);
    rd(SRC_CORE, SPACE_PROG, 22'h010000, IN0, G1, DT);
    rd(SRC_PROG, SPACE_PROG, 22'h00c000, IN0, G1, DT);
    $display("test external protect done");
    cfg(SRC_CORE, BOOT_EE_EXT_ADDR, 8'h7f, G1, 8'h7f);
    rd(SRC_PROG, SPACE_EEPROM, 22'h000010, IN0, G0, DZ);
    rd(SRC_CORE, SPACE_EEPROM, 22'h000010, IN0, G1, DT);
    cfg(SRC_CORE, BOOT_EE_CFG_WR_ADDR, 8'h7f, G1, 8'h3f);
    wr(SRC_CORE, SPACE_EEPROM, 22'h000010, G0);
    wr(SRC_PROG, SPACE_EEPROM, 22'h000010, G0);
    rd(SRC_CORE, SPACE_EEPROM, 22'h000011, IN0, G1, DT);
    $display("test eeprom done");
    rd(SRC_PROG, SPACE_OTHER, ID_LAST_ADDR, IN0, G1, DT);
    wr(SRC_CORE, SPACE_OTHER, ID_FIRST_ADDR, G1);
    rd(SRC_CORE, SPACE_OTHER, DEVID_FIRST_ADDR, IN0, G1, DT);
    rd(SRC_CORE, SPACE_PROG, 22'h018000, IN0, GX, DZ);
    rd(SRC_CORE, SPACE_PROG, 22'h017fff, IN0, G1, DT);
    // Block 5 bits stay at one throughout the small variant run
    small_variant = 1'b1;
    rd(SRC_CORE, SPACE_PROG, 22'h014000, IN0, GX, DZ);
    small_variant = 1'b0;
    $display("test id and unimplemented done");
    acc(SRC_PROG, OP_ROW_ERASE, SPACE_PROG, 22'h008000, IN0, 8'h00, G0, NC);
    acc(SRC_PROG, OP_ROW_ERASE, SPACE_PROG, 22'h00c000, IN0, 8'h00, G1, NC);
    cfg(SRC_CORE, BOOT_EE_CFG_WR_ADDR, 8'h1f, GX, 8'h3f);
    cfg(SRC_PROG, BOOT_EE_CFG_WR_ADDR, 8'hdf, G1, 8'h1f);
    cfg(SRC_CORE, BLOCK_XRD_ADDR, 8'h00, G0, 8'hfd);
    rd(SRC_CORE, SPACE_CONFIG, BLOCK_XRD_ADDR, IN0, G1, NC);
    chk("config read", 8'hfd, resp_rdata);
    $display("test config protect done");
    acc(SRC_CORE, OP_BLOCK_ERASE, SPACE_PROG, 22'h004000, IN0, 8'h00, G0, NC);
    acc(SRC_CORE, OP_CHIP_ERASE, SPACE_PROG, 22'h000000, IN0, 8'h00, G0, NC);
    chk("protect byte", 8'hfd, xrd_b);
    acc(SRC_PROG, OP_CHIP_ERASE, SPACE_PROG, 22'h000000, IN0, 8'h00, G1, NC);
    @(posedge sys_clk);
    #1;
    for (int i = 8; i < 14; i++) begin
      chk("erased byte", 8'hff, pbyte(i[3:0]));
    end
    $display("test erase done");
    // Held request with the enable low must leave no trace
    @(posedge sys_clk);
    #1;
    clk_en = 1'b0;
    req_valid = 1'b1;
    req_source = SRC_PROG;
    req_op = OP_WRITE;
    req_space = SPACE_CONFIG;
    req_addr = BLOCK_WR_ADDR;
    req_wdata = 8'h00;
    repeat (2) @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
    clk_en = 1'b1;
    chk("frozen resp_valid", 8'h00, {7'h00, resp_valid});
    @(posedge sys_clk);
    #1;
    chk("frozen protect byte", 8'hff, wr_b);
    $display("test clock enable done");
    print_verdict();
  end
endmodule
